/* hdl/bridge_cfg_map.svh */
// Offsets, field positions and fixed values of the bridge header fields
`ifndef BRIDGE_CFG_MAP_SVH
`define BRIDGE_CFG_MAP_SVH
`define OFF_CMD_STATUS 8'h04
`define OFF_REV_CLASS 8'h08
`define OFF_LINE_HDR 8'h0C
`define OFF_BUS_NUM 8'h18
`define OFF_EVENT_IN 8'h40
`define CMD_PARITY_EN 6
`define CMD_ERR_REPORT 8
`define ST_INT_PEND 19
`define ST_CAP_LIST 20
`define ST_PARITY 24
`define ST_SENT_CA 27
`define ST_RECV_CA 28
`define ST_RECV_UR 29
`define ST_SENT_ERR 30
`define ST_POISON 31
`define CMD_RW_MASK 16'h0547
`define W1C_MASK 32'hF9000000
`define CLASS_CODE 24'h060400
`define HDR_TYPE_VAL 8'h01
`define LAT_TIMER_VAL 8'h00
`define LINE_RESET 8'h00
`define BUS_RESET 8'h00
`define CAP_RESET 1'h1
`endif

/* hdl/bridge_cfg_pkg.sv */
// Types shared by the bridge header register block
package bridge_cfg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01
  } apb_state_t;
endpackage

/* hdl/bridge_config_header_fields.sv */
// Bridge configuration header fields: primary status, identity, bus numbers
// Behaviour
// - interrupt pending status bit reads zero always
// - capability list bit reads one after reset
// - legacy timing capability bits read zero
// - parity flag set only when parity enabled
// - sent completer abort sets its flag
// - received completer abort sets its flag
// - received unsupported request sets its flag
// - error message sent with reporting sets flag
// - poisoned packet received sets its flag
// - revision is a hardwired eight-bit value
// - class code reads bridge 060400
// - cache line size read-write, no effect
// - primary latency timer reads zero
// - header type reads 01h
// - primary bus number read-write, reset zero
// - secondary bus number read-write, reset zero
// - command bit 6 enables parity reaction
// - command bit 8 enables error reporting
`timescale 1ns/1ps
`include "bridge_cfg_map.svh"
module bridge_config_header_fields #(
  parameter logic [7:0] REVISION = 8'hA1  // Arbitrary value
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transaction-logic events, one-cycle pulses on pclk
  input wire logic ev_parity,
  input wire logic ev_sent_ca,
  input wire logic ev_recv_ca,
  input wire logic ev_recv_ur,
  input wire logic ev_sent_err,
  input wire logic ev_poison,
  // Control toward the port
  output logic parity_react_en,
  output logic error_report_enable,
  output logic [7:0] upstream_bus_number,
  output logic [7:0] downstream_bus_number
);
  bridge_cfg_pkg::apb_state_t state_r;
  logic [15:0] cmd_r;
  logic [31:0] flags_r;
  logic [7:0] line_r;
  logic [7:0] pri_bus_r;
  logic [7:0] sec_bus_r;
  logic [31:0] wmask;
  logic [31:0] rd_nxt;
  logic hit;
  logic wr_go;
  logic [5:0] ev_vec;
  logic [31:0] ev_set;

  // Byte enables expanded to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wmask[g*8 +: 8] = {8{pstrb[g]}};
    end
  endgenerate

  assign hit = (paddr == `OFF_CMD_STATUS) || (paddr == `OFF_REV_CLASS) ||
               (paddr == `OFF_LINE_HDR) || (paddr == `OFF_BUS_NUM);
  // Writes land only in the access phase, two-wait answer
  assign wr_go = clk_en && (state_r == bridge_cfg_pkg::ST_ACCESS) && psel && pwrite && hit;

  // APB sequencing: two wait states, then pready for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= bridge_cfg_pkg::ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      case (state_r)
        bridge_cfg_pkg::ST_IDLE:
        begin
          if (psel && penable && !pready)
          begin
            state_r <= bridge_cfg_pkg::ST_ACCESS;
          end
        end
        bridge_cfg_pkg::ST_ACCESS:
        begin
          pready <= 1'b1;
          pslverr <= !hit;
          state_r <= bridge_cfg_pkg::ST_IDLE;
        end
        default:
        begin
          state_r <= bridge_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Command bits this block uses; the other bits of CMD_RW_MASK stored for software only, the rest read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_r <= 16'h0000;
    end
    else if (wr_go && paddr == `OFF_CMD_STATUS)
    begin
      cmd_r <= (cmd_r & ~(wmask[15:0] & `CMD_RW_MASK)) | (pwdata[15:0] & wmask[15:0] & `CMD_RW_MASK);
    end
  end

  assign ev_vec = {ev_poison, ev_sent_err, ev_recv_ur, ev_recv_ca, ev_sent_ca, ev_parity};
  always_comb
  begin
    ev_set = 32'h00000000;
    ev_set[`ST_PARITY] = ev_vec[0] && cmd_r[`CMD_PARITY_EN];
    ev_set[`ST_SENT_CA] = ev_vec[1];
    ev_set[`ST_RECV_CA] = ev_vec[2];
    ev_set[`ST_RECV_UR] = ev_vec[3];
    ev_set[`ST_SENT_ERR] = ev_vec[4] && cmd_r[`CMD_ERR_REPORT];
    ev_set[`ST_POISON] = ev_vec[5];
  end

  // write-one clear, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (wr_go && paddr == `OFF_CMD_STATUS)
      begin
        flags_r <= ((flags_r & ~(pwdata & wmask & `W1C_MASK)) | ev_set) & `W1C_MASK;
      end
      else
      begin
        flags_r <= (flags_r | ev_set) & `W1C_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_r <= `LINE_RESET;
    end
    else if (wr_go && paddr == `OFF_LINE_HDR && pstrb[0])
    begin
      line_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pri_bus_r <= `BUS_RESET;
      sec_bus_r <= `BUS_RESET;
    end
    else if (wr_go && paddr == `OFF_BUS_NUM)
    begin
      if (pstrb[0])
      begin
        pri_bus_r <= pwdata[7:0];
      end
      if (pstrb[1])
      begin
        sec_bus_r <= pwdata[15:8];
      end
    end
  end

  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `OFF_CMD_STATUS:
      begin
        // those bits stay zero; capability set
        rd_nxt = flags_r | {16'h0000, cmd_r};
        rd_nxt[`ST_CAP_LIST] = `CAP_RESET;
      end
      `OFF_REV_CLASS: rd_nxt = {`CLASS_CODE, REVISION};
      `OFF_LINE_HDR: rd_nxt = {8'h00, `HDR_TYPE_VAL, `LAT_TIMER_VAL, line_r};
      `OFF_BUS_NUM: rd_nxt = {16'h0000, sec_bus_r, pri_bus_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Read data registered with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      prdata <= (state_r == bridge_cfg_pkg::ST_ACCESS && !pwrite) ? rd_nxt : 32'h00000000;
    end
  end

  // Registered copies to the port logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parity_react_en <= 1'b0;
      error_report_enable <= 1'b0;
      upstream_bus_number <= `BUS_RESET;
      downstream_bus_number <= `BUS_RESET;
    end
    else if (clk_en)
    begin
      parity_react_en <= cmd_r[`CMD_PARITY_EN];
      error_report_enable <= cmd_r[`CMD_ERR_REPORT];
      upstream_bus_number <= pri_bus_r;
      downstream_bus_number <= sec_bus_r;
    end
  end

  a_parity_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_PARITY]) |-> $past(cmd_r[`CMD_PARITY_EN]))
    else $error("parity flag set while disabled");

  a_parity_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_parity && cmd_r[`CMD_PARITY_EN] |=> flags_r[`ST_PARITY])
    else $error("parity flag missed");

  a_sent_ca: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_sent_ca |=> flags_r[`ST_SENT_CA])
    else $error("sent abort flag missed");

  a_sent_ca_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_SENT_CA]) |-> $past(ev_sent_ca) && $past(clk_en))
    else $error("sent abort flag without cause");

  a_recv_ca: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_recv_ca |=> flags_r[`ST_RECV_CA])
    else $error("received abort flag missed");

  a_recv_ca_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_RECV_CA]) |-> $past(ev_recv_ca) && $past(clk_en))
    else $error("received abort flag without cause");

  a_recv_ur: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_recv_ur |=> flags_r[`ST_RECV_UR])
    else $error("unsupported flag missed");

  a_recv_ur_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_RECV_UR]) |-> $past(ev_recv_ur) && $past(clk_en))
    else $error("unsupported flag without cause");

  a_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_SENT_ERR]) |-> $past(cmd_r[`CMD_ERR_REPORT]) && $past(ev_sent_err))
    else $error("error flag set without cause");

  a_err_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_sent_err && cmd_r[`CMD_ERR_REPORT] |=> flags_r[`ST_SENT_ERR])
    else $error("error flag missed");

  a_poison_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev_poison |=> flags_r[`ST_POISON])
    else $error("poison flag missed");

  a_poison_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_r[`ST_POISON]) |-> $past(ev_poison) && $past(clk_en))
    else $error("poison flag without cause");

  a_status_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `OFF_CMD_STATUS |-> !prdata[`ST_INT_PEND] && prdata[`ST_CAP_LIST]
      && prdata[23:21] == 3'b000 && prdata[26:25] == 2'b00)
    else $error("fixed status bits wrong");

  a_int_pend_low: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_r[`ST_INT_PEND] && !prdata[`ST_INT_PEND])
    else $error("interrupt pending bit set");

  a_legacy_zero: assert property (@(posedge pclk) disable iff (!presetn)
    flags_r[23:19] == 5'h00 && flags_r[26:25] == 2'h0)
    else $error("legacy status bits set");

  a_rev_word: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `OFF_REV_CLASS |-> prdata == {`CLASS_CODE, REVISION})
    else $error("identity word wrong");

  a_hdr_word: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `OFF_LINE_HDR |-> prdata[31:8] == {8'h00, `HDR_TYPE_VAL, `LAT_TIMER_VAL})
    else $error("header bytes wrong");

  a_line_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == `OFF_LINE_HDR && pstrb[0] |=> line_r == $past(pwdata[7:0]))
    else $error("cache line not written");

  a_bus_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == `OFF_BUS_NUM && pstrb[0] |=> ##1 upstream_bus_number == $past(pwdata[7:0], 2))
    else $error("bus number not written");

  a_sec_bus_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == `OFF_BUS_NUM && pstrb[1] |=> ##1 downstream_bus_number == $past(pwdata[15:8], 2))
    else $error("secondary bus number not written");

  a_parity_copy: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> parity_react_en == $past(cmd_r[`CMD_PARITY_EN]))
    else $error("parity enable copy wrong");

  a_err_copy: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> error_report_enable == $past(cmd_r[`CMD_ERR_REPORT]))
    else $error("report enable copy wrong");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == `OFF_CMD_STATUS && pstrb[3] && pwdata[`ST_POISON] && !ev_poison |=> !flags_r[`ST_POISON])
    else $error("poison flag not cleared");

  a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    flags_r[`ST_POISON] && !(wr_go && paddr == `OFF_CMD_STATUS && pstrb[3] && pwdata[`ST_POISON])
      |=> flags_r[`ST_POISON])
    else $error("poison flag lost");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !hit |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule

/* tb/tb.sv */
// Self-checking bench for the bridge header field register block
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] ev = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic parity_react_en;
  logic error_report_enable;
  logic [7:0] upstream_bus_number;
  logic [7:0] downstream_bus_number;
  int miscompares = 0;
  int check_count = 0;

  // Arbitrary revision value
  bridge_config_header_fields #(.REVISION(8'h5C)) u_bridge_config_header_fields (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_parity(ev[0]), .ev_sent_ca(ev[1]), .ev_recv_ca(ev[2]), .ev_recv_ur(ev[3]), .ev_sent_err(ev[4]),
    .ev_poison(ev[5]), .parity_react_en(parity_react_en), .error_report_enable(error_report_enable),
    .upstream_bus_number(upstream_bus_number), .downstream_bus_number(downstream_bus_number)
  );

  always #12.5 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Master never assumes a latency; only the bound stops a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready between edges, where it has settled
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      $display("ERROR %0t: no pready", $time);
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    // Request stands until the edge that samples pready high
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h00000000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    check({31'h0, e}, {31'h0, exp_err});
    check(r, exp);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 6'h00;
  endtask

  task automatic t_reset_values;
    rd(8'h04, 32'h00100000, 1'b0);
    rd(8'h08, 32'h0604005C, 1'b0);
    rd(8'h0C, 32'h00010000, 1'b0);
    rd(8'h18, 32'h00000000, 1'b0);
  endtask

  task automatic t_rw_fields;
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h000100FF, 1'b0);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h0604005C, 1'b0);
    wr(8'h18, 32'hFFFF3A7C);
    rd(8'h18, 32'h00003A7C, 1'b0);
    check({24'h0, upstream_bus_number}, 32'h0000007C);
    check({24'h0, downstream_bus_number}, 32'h0000003A);
    wr(8'h18, 32'h000000C5);
    rd(8'h18, 32'h000000C5, 1'b0);
    // Only the second byte lane is written
    pstrb <= 4'h2;
    wr(8'h18, 32'h0000EE11);
    pstrb <= 4'hF;
    rd(8'h18, 32'h0000EEC5, 1'b0);
    // Unmapped word: refused with an error, reads zero
    rd(8'h20, 32'h00000000, 1'b1);
  endtask

  task automatic t_status_flags;
    wr(8'h04, 32'h00000000);
    pulse(6'h11);
    rd(8'h04, 32'h00100000, 1'b0);
    wr(8'h04, 32'h00000140);
    @(negedge pclk);
    check({31'h0, parity_react_en}, 32'h00000001);
    check({31'h0, error_report_enable}, 32'h00000001);
    pulse(6'h3F);
    rd(8'h04, 32'hF9100140, 1'b0);
    wr(8'h04, 32'h08000140);
    rd(8'h04, 32'hF1100140, 1'b0);
    wr(8'h04, 32'h06F80140);
    rd(8'h04, 32'hF1100140, 1'b0);
    wr(8'h04, 32'hFF000140);
    rd(8'h04, 32'h00100140, 1'b0);
    wr(8'h04, 32'h0000FFFF);
    rd(8'h04, 32'h00100547, 1'b0);
    wr(8'h04, 32'h00000000);
    @(negedge pclk);
    check({30'h0, parity_react_en, error_report_enable}, 32'h00000000);
  endtask

  // Frozen block ignores events and stalls its answer
  task automatic t_clk_en_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    pulse(6'h20);
    fork
      rd(8'h18, 32'h0000EEC5, 1'b0);
      begin
        repeat (6) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    rd(8'h04, 32'h00100000, 1'b0);
  endtask

  // Second reset in mid-run clears flags and fields
  task automatic t_reset_mid;
    pulse(6'h20);
    rd(8'h04, 32'h80100000, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({16'h0, upstream_bus_number, downstream_bus_number}, 32'h00000000);
    t_reset_values();
  endtask

  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_rw_fields();
    t_status_flags();
    t_clk_en_freeze();
    t_reset_mid();
    conclude();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #50000;
    miscompares++;
    conclude();
  end
endmodule
